// ==== include/tmon_consts.vh ====
// Constants of the two-channel temperature monitor: command codes,
// reset values, bit positions and timing figures.
// Assumes a core clock of 125 MHz; included by bare name.
`ifndef TMON_CONSTS_VH
`define TMON_CONSTS_VH

// Command codes (register pointer values)
`define TMON_CMD_LTEMP   8'h00
`define TMON_CMD_RTEMP   8'h01
`define TMON_CMD_STAT    8'h02
`define TMON_CMD_CFG_RD  8'h03
`define TMON_CMD_LLIM_RD 8'h05
`define TMON_CMD_RLIM_RD 8'h07
`define TMON_CMD_CFG_WR  8'h09
`define TMON_CMD_LLIM_WR 8'h0b
`define TMON_CMD_RLIM_WR 8'h0d
`define TMON_CMD_ONESHOT 8'h0f
`define TMON_CMD_RFRAC   8'h10
`define TMON_CMD_LFRAC   8'h11
`define TMON_CMD_IDENT   8'hfe

// Reset values
`define TMON_CMD_RST     8'h00
`define TMON_CFG_RST     8'h10
`define TMON_LLIM_RST    8'h46
`define TMON_RLIM_RST    8'h78
`define TMON_TEMP_RST    8'h00

// Configuration and status bit positions
`define TMON_CFG_MASK    7
`define TMON_CFG_STBY    6
`define TMON_CFG_RONLY   5
`define TMON_CFG_FQ      4
`define TMON_CFG_WMASK   8'hf0
`define TMON_ST_BUSY     7
`define TMON_ST_LHI      6
`define TMON_ST_RHI      4
`define TMON_ST_OPEN     2

// Diode fault reading, fraction padding, alert response address
`define TMON_DIODE_FAULT 8'hff
`define TMON_FRAC_PAD    6'h00
`define TMON_ARA         7'h0c
`define TMON_FQ_DEPTH    2'd2

// Timing: clock in kHz, periods and conversion time in ms
`define TMON_CLK_KHZ     125000
`define TMON_PER_NORM_MS 250
`define TMON_PER_FAST_MS 125
`define TMON_CONV_MS     50

`endif

// ==== verilog/tmon_smb_link.v ====
// Two-wire serial slave: start/stop detection, byte shifting, ack,
// register-pointer and data strobes, and the alert response reply.
// Assumes scl_in/sda_in come from pins; sda is open drain.
`timescale 1ns/1ps
`include "tmon_consts.vh"

module tmon_smb_link #(
	parameter [6:0] DEV_ADDR = 7'h48
) (
	input  wire       core_clk,  // Core clock
	input  wire       sys_rst,   // Synchronous reset, high
	input  wire       scl_in,    // Serial clock pin level
	input  wire       sda_in,    // Serial data pin level
	input  wire       ara_pend,  // Alert latched, answer ARA
	input  wire [7:0] tx_data,   // Byte to send on a read
	output reg        sda_oe,    // Pull sda low
	output reg  [7:0] rx_byte,   // Last written byte
	output reg        cmd_stb,   // Pointer byte received
	output reg        dat_stb,   // Data byte received
	output reg        rd_stb,    // Read byte sent
	output reg        ara_stb    // Alert response sent without loss
);

	localparam L_IDLE = 7'b0000001;
	localparam L_ADDR = 7'b0000010;
	localparam L_AACK = 7'b0000100;
	localparam L_WR   = 7'b0001000;
	localparam L_WACK = 7'b0010000;
	localparam L_RD   = 7'b0100000;
	localparam L_RACK = 7'b1000000;

	reg       scl_s1, scl_s2, scl_d;
	reg       sda_s1, sda_s2, sda_d;
	reg [6:0] st;
	reg [3:0] cnt;
	reg [7:0] sr;
	reg       rw, ara, first, mack;

	wire       scl_r = scl_s2 & ~scl_d;
	wire       scl_f = ~scl_s2 & scl_d;
	wire       start = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire       stop  = scl_s2 & scl_d & ~sda_d & sda_s2;
	wire [7:0] load  = ara ? {DEV_ADDR, 1'b0} : tx_data;
	wire       hit_dev = (sr[7:1] == DEV_ADDR);
	wire       hit_ara = (sr[7:1] == `TMON_ARA) & sr[0] & ara_pend;

	// Two-stage synchronisers; the second stage and its one-cycle delayed copy are used
	always @(posedge core_clk) begin
		if (sys_rst) begin
			{scl_s1, scl_s2, scl_d} <= 3'h7;
			{sda_s1, sda_s2, sda_d} <= 3'h7;
		end else begin
			{scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
		end
	end

	// Bit engine: sample on scl rise, drive on scl fall
	always @(posedge core_clk) begin
		if (sys_rst) begin
			st <= L_IDLE;
			cnt <= 4'h0;
			sr <= 8'h00;
			{rw, ara, first, mack, sda_oe} <= 5'h00;
			rx_byte <= 8'h00;
			{cmd_stb, dat_stb, rd_stb, ara_stb} <= 4'h0;
		end else begin
			{cmd_stb, dat_stb, rd_stb, ara_stb} <= 4'h0;
			if (start) begin
				st <= L_ADDR;
				cnt <= 4'h0;
				sda_oe <= 1'b0;
				first <= 1'b1;
			end else if (stop) begin
				st <= L_IDLE;
				sda_oe <= 1'b0;
			end else case (st)
			L_ADDR, L_WR: begin
				if (scl_r && cnt != 4'h8) begin
					sr <= {sr[6:0], sda_s2};
					cnt <= cnt + 4'h1;
				end else if (scl_f && cnt == 4'h8) begin
					if (st == L_WR) begin
						rx_byte <= sr;
						sda_oe <= 1'b1;
						cmd_stb <= first;
						dat_stb <= ~first;
						first <= 1'b0;
						st <= L_WACK;
					end else if (hit_dev || hit_ara) begin
						sda_oe <= 1'b1;
						rw <= sr[0];
						ara <= ~hit_dev;
						st <= L_AACK;
					end else
						st <= L_IDLE;
				end
			end
			L_AACK, L_WACK: if (scl_f) begin
				cnt <= 4'h0;
				if (rw && st == L_AACK) begin
					sr <= load;
					sda_oe <= ~load[7];
					st <= L_RD;
				end else begin
					sda_oe <= 1'b0;
					st <= L_WR;
				end
			end
			L_RD: begin
				if (scl_r) begin
					// Lower address wins: a released one seen low loses
					if (ara && !sda_oe && !sda_s2)
						st <= L_IDLE;
					else
						cnt <= cnt + 4'h1;
				end else if (scl_f) begin
					if (cnt == 4'h8) begin
						sda_oe <= 1'b0;
						rd_stb <= ~ara;
						ara_stb <= ara;
						st <= L_RACK;
					end else begin
						sr <= {sr[6:0], 1'b0};
						sda_oe <= ~sr[6];
					end
				end
			end
			L_RACK: begin
				if (scl_r)
					mack <= ~sda_s2;
				else if (scl_f) begin
					cnt <= 4'h0;
					if (mack && !ara) begin
						sr <= load;
						sda_oe <= ~load[7];
						st <= L_RD;
					end else
						st <= L_IDLE;
				end
			end
			default: st <= L_IDLE;
			endcase
		end
	end

endmodule // tmon_smb_link

// ==== verilog/tmon_top.v ====
// Register, alarm and conversion control of a two-channel temperature
// monitor reached over a two-wire serial slave port.
// Assumes ADC results arrive on the core clock; bus pins are async.
`timescale 1ns/1ps
`include "tmon_consts.vh"

module tmon_top #(
	parameter [6:0]  DEV_ADDR   = 7'h48,  // One of 1001 000..1001 111
	parameter [7:0]  IDENT      = 8'h5a,  // Arbitrary identity value
	parameter        TW         = 25,
	parameter [24:0] PER_NORM   = `TMON_PER_NORM_MS * `TMON_CLK_KHZ,
	parameter [24:0] PER_FAST   = `TMON_PER_FAST_MS * `TMON_CLK_KHZ,
	parameter [24:0] CONV_CYC   = `TMON_CONV_MS * `TMON_CLK_KHZ
) (
	input  wire       core_clk,     // 125 MHz core clock
	input  wire       sys_rst,      // Synchronous reset, high
	input  wire       scl_in,       // Serial clock pin
	input  wire       sda_in,       // Serial data pin level
	output reg        sda_out,      // Serial data drive level
	output wire       sda_oe,       // Serial data drive enable
	output reg        alert_out,    // Alert drive level (low)
	output reg        alert_oe,     // Alert drive enable
	input  wire [9:0] local_adc,    // Local result, 0.25 C steps
	input  wire [9:0] remote_adc,   // Remote result, 0.25 C steps
	input  wire       remote_junction_open // Remote diode fault
);

	localparam S_IDLE = 4'b0001;
	localparam S_LOC  = 4'b0010;
	localparam S_REM  = 4'b0100;
	localparam S_WAIT = 4'b1000;

	////////////////////////////////////////////////////////////////
	// Declarations
	reg  [7:0]    cmd;
	reg  [7:0]    cfg;
	reg  [7:0]    llim;
	reg  [7:0]    rlim;
	reg  [7:0]    ltemp;
	reg  [7:0]    rtemp;
	reg  [7:0]    lfrac;
	reg  [7:0]    rfrac;
	reg  [7:0]    rd_data;
	reg  [3:0]    st;
	reg  [TW-1:0] conv_t;
	reg  [TW-1:0] per_t;
	reg           oneshot;
	reg  [1:0]    lfq;
	reg  [1:0]    rfq;
	reg           lover;
	reg           rover;
	reg           open_cond;
	reg           local_over_limit_flag;
	reg           remote_over_limit_flag;
	reg           open_flag;
	reg           alert_latch;
	reg  [7:0]    stat;
	wire [7:0]    rx_byte;
	wire          cmd_stb;
	wire          dat_stb;
	wire          rd_stb;
	wire          ara_stb;

	wire irq_mask_bit = cfg[`TMON_CFG_MASK];
	wire stby         = cfg[`TMON_CFG_STBY];
	wire ronly        = cfg[`TMON_CFG_RONLY];
	wire fq_on        = cfg[`TMON_CFG_FQ];
	wire busy         = st[1] | st[2];
	wire conv_end     = (conv_t == CONV_CYC - 25'h1);
	wire loc_done     = (st == S_LOC) & conv_end;
	wire rem_done     = (st == S_REM) & conv_end;
	wire [TW-1:0] per_len = ronly ? PER_FAST : PER_NORM;
	wire ss_cmd       = cmd_stb & (rx_byte == `TMON_CMD_ONESHOT);
	wire ss_go        = ss_cmd & stby & (st == S_IDLE);
	wire stat_rd      = rd_stb & (cmd == `TMON_CMD_STAT);

	////////////////////////////////////////////////////////////////
	// Functions

	// Next fault-queue count: saturates, restarts on a clean reading
	function [1:0] fq_next;
		input       over;
		input [1:0] c;
		begin
			if (!over)
				fq_next = 2'd0;
			else if (c == `TMON_FQ_DEPTH)
				fq_next = c;
			else
				fq_next = c + 2'd1;
		end
	endfunction

	// A reading counts toward the alert once the queue is satisfied
	function qualify;
		input       over;
		input [1:0] c;
		input       queue;
		begin
			qualify = over & (!queue | (fq_next(over, c) == `TMON_FQ_DEPTH));
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Serial slave port

	tmon_smb_link #(
		.DEV_ADDR (DEV_ADDR)
	) u_link (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.ara_pend (alert_latch),
		.tx_data  (rd_data),
		.sda_oe   (sda_oe),
		.rx_byte  (rx_byte),
		.cmd_stb  (cmd_stb),
		.dat_stb  (dat_stb),
		.rd_stb   (rd_stb),
		.ara_stb  (ara_stb)
	);

	////////////////////////////////////////////////////////////////
	// Register pointer and writable registers

	// Pointer updates on every pointer byte; data byte goes to it
	always @(posedge core_clk) begin
		if (sys_rst) begin
			cmd  <= `TMON_CMD_RST;
			cfg  <= `TMON_CFG_RST;
			llim <= `TMON_LLIM_RST;
			rlim <= `TMON_RLIM_RST;
		end else begin
			if (cmd_stb)
				cmd <= rx_byte;
			if (dat_stb) begin
				case (cmd)
				`TMON_CMD_CFG_WR:  cfg  <= rx_byte & `TMON_CFG_WMASK;
				`TMON_CMD_LLIM_WR: llim <= rx_byte;
				`TMON_CMD_RLIM_WR: rlim <= rx_byte;
				default: ;
				endcase
			end
		end
	end

	// Status byte view; reserved bits stay zero
	always @* begin
		stat = 8'h00;
		stat[`TMON_ST_BUSY] = busy;
		stat[`TMON_ST_LHI]  = local_over_limit_flag;
		stat[`TMON_ST_RHI]  = remote_over_limit_flag;
		stat[`TMON_ST_OPEN] = open_flag;
	end

	// Read data is registered so the link loads a stable byte
	always @(posedge core_clk) begin
		if (sys_rst)
			rd_data <= 8'h00;
		else begin
			case (cmd)
			`TMON_CMD_LTEMP:   rd_data <= ltemp;
			`TMON_CMD_RTEMP:   rd_data <= rtemp;
			`TMON_CMD_STAT:    rd_data <= stat;
			`TMON_CMD_CFG_RD:  rd_data <= cfg;
			`TMON_CMD_LLIM_RD: rd_data <= llim;
			`TMON_CMD_RLIM_RD: rd_data <= rlim;
			`TMON_CMD_RFRAC:   rd_data <= rfrac;
			`TMON_CMD_LFRAC:   rd_data <= lfrac;
			`TMON_CMD_IDENT:   rd_data <= IDENT;
			default:           rd_data <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Conversion scheduler

	// A cycle is local then remote (remote only when ronly is set), then a wait to fill the period.
	// Standby is honoured after the remote conversion or at once in the wait, so a running
	// conversion is never cut short and its results stay coherent.
	always @(posedge core_clk) begin
		if (sys_rst) begin
			st      <= S_LOC;
			conv_t  <= {TW{1'b0}};
			per_t   <= {TW{1'b0}};
			oneshot <= 1'b0;
		end else begin
			case (st)
			S_IDLE: begin
				conv_t <= {TW{1'b0}};
				per_t  <= {TW{1'b0}};
				if (ss_go) begin
					oneshot <= 1'b1;
					st <= ronly ? S_REM : S_LOC;
				end else if (!stby)
					st <= ronly ? S_REM : S_LOC;
			end
			S_LOC: begin
				per_t <= per_t + 25'h1;
				conv_t <= conv_end ? {TW{1'b0}} : conv_t + 25'h1;
				if (conv_end)
					st <= S_REM;
			end
			S_REM: begin
				per_t <= per_t + 25'h1;
				conv_t <= conv_end ? {TW{1'b0}} : conv_t + 25'h1;
				if (conv_end) begin
					oneshot <= 1'b0;
					st <= (oneshot | stby) ? S_IDLE : S_WAIT;
				end
			end
			S_WAIT: begin
				per_t <= per_t + 25'h1;
				if (stby)
					st <= S_IDLE;
				else if (per_t >= per_len - 25'h1) begin
					per_t <= {TW{1'b0}};
					st <= ronly ? S_REM : S_LOC;
				end
			end
			default: st <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Result registers and limit comparison

	// Main and fraction bytes move together at the channel's end
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ltemp <= `TMON_TEMP_RST;
			lfrac <= `TMON_TEMP_RST;
			rtemp <= `TMON_TEMP_RST;
			rfrac <= `TMON_TEMP_RST;
			lover <= 1'b0;
			rover <= 1'b0;
			lfq   <= 2'd0;
			rfq   <= 2'd0;
			open_cond <= 1'b0;
		end else begin
			if (loc_done) begin
				ltemp <= local_adc[9:2];
				lfrac <= {local_adc[1:0], `TMON_FRAC_PAD};
				lover <= (local_adc[9:2] >= llim);
				lfq   <= fq_next(local_adc[9:2] >= llim, lfq);
			end
			if (rem_done) begin
				open_cond <= remote_junction_open;
				if (remote_junction_open) begin
					rtemp <= `TMON_DIODE_FAULT;
					rfrac <= `TMON_TEMP_RST;
					rover <= 1'b0;
					rfq   <= 2'd0;
				end else begin
					rtemp <= remote_adc[9:2];
					rfrac <= {remote_adc[1:0], `TMON_FRAC_PAD};
					rover <= (remote_adc[9:2] >= rlim);
					rfq   <= fq_next(remote_adc[9:2] >= rlim, rfq);
				end
			end
		end
	end

	// Per-channel raw and queued fault results of this cycle
	wire l_over_now = loc_done & (local_adc[9:2] >= llim);
	wire r_over_now = rem_done & ~remote_junction_open & (remote_adc[9:2] >= rlim);
	wire l_qual = loc_done & qualify(local_adc[9:2] >= llim, lfq, fq_on);
	wire r_qual = r_over_now & qualify(1'b1, rfq, fq_on);
	wire fault_gone = ~lover & ~rover;

	////////////////////////////////////////////////////////////////
	// Status flags

	// A fault in the same cycle as a status read wins over the clear
	always @(posedge core_clk) begin
		if (sys_rst) begin
			local_over_limit_flag  <= 1'b0;
			remote_over_limit_flag <= 1'b0;
			open_flag              <= 1'b0;
		end else begin
			if (l_over_now)
				local_over_limit_flag <= 1'b1;
			else if (stat_rd)
				local_over_limit_flag <= 1'b0;
			if (r_over_now)
				remote_over_limit_flag <= 1'b1;
			else if (stat_rd)
				remote_over_limit_flag <= 1'b0;
			if (rem_done & remote_junction_open)
				open_flag <= 1'b1;
			else if (stat_rd & ~open_cond)
				open_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Alert latch and open-drain pin

	// Only limit faults feed the latch; the open diode never does.
	// After an alert response the saturated queue count makes the
	// next persisting reading set the latch again at once.
	always @(posedge core_clk) begin
		if (sys_rst) begin
			alert_latch <= 1'b0;
			alert_oe    <= 1'b0;
			alert_out   <= 1'b0;
			sda_out     <= 1'b0;
		end else begin
			if ((l_qual | r_qual) & ~irq_mask_bit)
				alert_latch <= 1'b1;
			else if (ara_stb)
				alert_latch <= 1'b0;
			else if (stat_rd & fault_gone)
				alert_latch <= 1'b0;
			alert_oe  <= alert_latch;
			alert_out <= 1'b0;
			sda_out   <= 1'b0;
		end
	end

endmodule // tmon_top

// ==== test/tmon_assertions.sv ====
// Checker for the monitor's pins: bus drive timing and alert latching.
// Assumes the top module's ports only; bound by the statement below.
`timescale 1ns/1ps
module tmon_chk (
	input logic core_clk,  // Core clock
	input logic sys_rst,   // Synchronous reset
	input logic scl_in,    // Serial clock pin
	input logic sda_in,    // Serial data wire
	input logic sda_out,   // Data drive level
	input logic sda_oe,    // Data drive enable
	input logic alert_out, // Alert drive level
	input logic alert_oe   // Alert drive enable
);
	logic [7:0] scl_age;  // Cycles since the clock pin moved
	logic       scl_d;    // Clock pin, one cycle late
	logic       sda_d;    // Data wire, one cycle late
	logic       in_frame; // Between start and stop on the raw pins
	////////////////////////////////////////
	// Age saturates so a long idle stays recognisable
	always @(posedge core_clk) begin
		scl_d <= scl_in;
		sda_d <= sda_in;
		if (sys_rst) begin
			scl_age <= 8'hff;
			in_frame <= 1'b0;
		end else begin
			scl_age <= (scl_in != scl_d) ? 8'h00 : scl_age + {7'h00, scl_age != 8'hff};
			if (scl_in && scl_d && sda_d && !sda_in)
				in_frame <= 1'b1;
			else if (scl_in && scl_d && !sda_d && sda_in)
				in_frame <= 1'b0;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	a_reset_quiet: assert property ($fell(sys_rst) |-> !alert_oe && !sda_oe)
		else $error("outputs active after reset");
	a_drive_level: assert property (!sda_out && !alert_out)
		else $error("open drain level not low");
	a_sda_hold: assert property (scl_in && scl_d |-> $stable(sda_oe))
		else $error("data moved while clock high");
	a_sda_launch: assert property ($changed(sda_oe) |-> scl_age inside {[1:8]})
		else $error("data not launched after clock fall");
	a_frame_only: assert property (sda_oe |-> in_frame)
		else $error("data driven outside a frame");
	a_idle_release: assert property (scl_in && scl_age == 8'hff |-> !sda_oe)
		else $error("data held on an idle bus");
	a_alert_clear_bus: assert property ($fell(alert_oe) |-> scl_age < 8'd64)
		else $error("alert released without bus traffic");
	a_alert_steady: assert property ($rose(alert_oe) |=> alert_oe [*3])
		else $error("alert not latched");
	c_alert_set: cover property ($rose(alert_oe));
	c_alert_clr: cover property ($fell(alert_oe));
	c_ack: cover property ($rose(sda_oe));
endmodule // tmon_chk
bind tmon_top tmon_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
	.alert_oe(alert_oe));

// ==== test/tmon_host.sv ====
// Bus master model: start, stop and byte transfers on an open drain wire.
// Assumes a pull-up on the data wire; the clock stands high between frames.
`timescale 1ns/1ps
module tmon_host (
	input  logic clk,      // Core clock, used only to place the edges
	output logic scl,      // Serial clock, 160 ns bit time
	output logic sda_pull, // High pulls the data wire low
	input  logic sda       // Resolved data wire
);
	////////////////////////////////////////
	// Both lines released at time zero
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task q;
		#40;
	endtask
	// Start or repeated start; aligning to the falling edge keeps every
	// later pin edge (all on a 40 ns grid) off the core clock's sampling edge
	task start;
		@(negedge clk);
		sda_pull = 1'b0;
		q;
		scl = 1'b1;
		q;
		sda_pull = 1'b1;
		q;
		scl = 1'b0;
		q;
	endtask
	task stop;
		sda_pull = 1'b1;
		q;
		scl = 1'b1;
		q;
		sda_pull = 1'b0;
		q;
	endtask
	// Eight bits MSB first, then the ack bit; sampled with the clock high
	task xb(input [7:0] d, input ak, output [7:0] r, output a);
		integer i;
		for (i = 8; i >= 0; i--) begin
			sda_pull = (i > 0) ? !d[i-1] : !ak;
			q;
			scl = 1'b1;
			q;
			if (i > 0)
				r[i-1] = sda;
			else
				a = sda;
			q;
			scl = 1'b0;
			q;
		end
	endtask
endmodule // tmon_host

// ==== test/tb.sv ====
// Self-checking bench: the master model reads and writes registers while
// the bench moves the ADC inputs. Assumes the checker is bound to dut.
`timescale 1ns/1ps
module tb;
	localparam [6:0] ADDR = 7'h4b; // One of the eight fixed codes
	localparam [7:0] IDV  = 8'h3c; // Arbitrary identity value
	logic       core_clk, sys_rst;
	logic [9:0] local_adc, remote_adc, la, ra;
	logic       remote_junction_open, a;
	wire        scl, sda_pull, sda_w, sda_oe, sda_out, alert_oe, alert_out;
	integer     bad_count, samples_checked, seed, i;
	logic [7:0] v, r;
	logic [7:0] rc [6] = '{8'h03, 8'h05, 8'h07, 8'hfe, 8'h04, 8'h0c};
	logic [7:0] re [6] = '{8'h10, 8'h46, 8'h78, IDV, 8'h00, 8'h00};
	// Pull-up wire: low while either party drives
	assign sda_w = ~(sda_pull | (sda_oe & ~sda_out));
	tmon_top #(.DEV_ADDR(ADDR), .IDENT(IDV), .PER_NORM(25'd100), .PER_FAST(25'd60),
		.CONV_CYC(25'd20)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
		.alert_oe(alert_oe), .local_adc(local_adc), .remote_adc(remote_adc),
		.remote_junction_open(remote_junction_open));
	tmon_host host (.clk(core_clk), .scl(scl), .sda_pull(sda_pull), .sda(sda_w));
	////////////////////////////////////////
	function [7:0] ti(input [9:0] x);
		ti = x[9:2];
	endfunction
	function [7:0] tf(input [9:0] x);
		tf = {x[1:0], 6'h00};
	endfunction
	task chk8(input [7:0] g, input [7:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t byte %h expected %h", $time, g, e);
		end
	endtask
	task chk1(input g, input e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t bit %b expected %b", $time, g, e);
		end
	endtask
	// Ends on a falling edge so outputs read next are settled
	task w(input integer n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task adc(input [9:0] l, input [9:0] m, input o);
		@(posedge core_clk);
		local_adc <= l;
		remote_adc <= m;
		remote_junction_open <= o;
	endtask
	task adr(input [7:0] b, input e);
		host.xb(b, 1'b1, r, a);
		chk1(a, e);
	endtask
	// Receive Byte from an address; e is the expected ack level
	task rx(input [6:0] ad, input e, output [7:0] d);
		host.start;
		adr({ad, 1'b1}, e);
		host.xb(8'hff, 1'b1, d, a);
		host.stop;
	endtask
	// Write Byte, or Send Byte when one is set
	task wr(input [7:0] c, input [7:0] d, input one);
		host.start;
		adr({ADDR, 1'b0}, 1'b0);
		adr(c, 1'b0);
		if (!one)
			adr(d, 1'b0);
		host.stop;
	endtask
	// Read Byte through a repeated start
	task rd(input [7:0] c, output [7:0] d);
		host.start;
		adr({ADDR, 1'b0}, 1'b0);
		adr(c, 1'b0);
		rx(ADDR, 1'b0, d);
	endtask
	task rdc(input [7:0] c, input [7:0] e);
		rd(c, v);
		chk8(v, e);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// A hang is cut short well past the expected run length
	initial begin
		#600000;
		bad_count++;
		finish_test;
	end
	initial begin
		seed = 32'h0c625d77;
		bad_count = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		local_adc = 10'h0a5;
		remote_adc = 10'h12e;
		remote_junction_open = 1'b0;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		w(4);
		rx(ADDR, 1'b0, v);
		chk8(v, ti(10'h0a5));
		for (i = 0; i < 6; i++)
			rdc(rc[i], re[i]);
		// Random readings under the limits, first one just below
		for (i = 0; i < 4; i++) begin
			la = (i == 0) ? 10'h117 : {2'b00, 8'($random(seed))};
			// Remote kept below its reset limit of 78h
			ra = 10'($random(seed)) % 10'h1e0;
			adc(la, ra, 1'b0);
			w(250);
			rdc(8'h00, ti(la));
			rdc(8'h11, tf(la));
			rdc(8'h01, ti(ra));
			rdc(8'h10, tf(ra));
		end
		rd(8'h02, v);
		rd(8'h02, v);
		chk8(v & 8'h7f, 8'h00);
		adc(10'h0bc, 10'h0b0, 1'b0);
		wr(8'h0b, 8'h30, 1'b0);
		wr(8'h0d, 8'h31, 1'b0);
		rdc(8'h05, 8'h30);
		rdc(8'h07, 8'h31);
		w(250);
		chk1(alert_oe, 1'b0);
		// Local equal to its limit faults; two in a row needed
		adc(10'h0c0, 10'h0b0, 1'b0);
		w(250);
		chk1(alert_oe, 1'b1);
		rd(8'h02, v);
		chk8(v & 8'h50, 8'h40);
		chk1(alert_oe, 1'b1);
		rx(7'h0c, 1'b0, v);
		chk8(v, {ADDR, 1'b0});
		w(150);
		chk1(alert_oe, 1'b1);
		adc(10'h0bc, 10'h0b0, 1'b0);
		w(250);
		rd(8'h02, v);
		chk1(alert_oe, 1'b0);
		rx(7'h0c, 1'b1, v);
		rx(ADDR ^ 7'h01, 1'b1, v);
		wr(8'h09, 8'h8f, 1'b0);
		rdc(8'h03, 8'h80);
		adc(10'h0c0, 10'h0b0, 1'b0);
		w(250);
		chk1(alert_oe, 1'b0);
		rd(8'h02, v);
		chk8(v & 8'h40, 8'h40);
		// Diode fault with a single-fault queue
		adc(10'h0bc, 10'h0b0, 1'b1);
		w(250);
		wr(8'h09, 8'h00, 1'b0);
		w(250);
		rd(8'h02, v);
		rd(8'h02, v);
		chk8(v & 8'h54, 8'h04);
		chk1(alert_oe, 1'b0);
		rdc(8'h01, 8'hff);
		adc(10'h0bc, 10'h0c6, 1'b0);
		w(250);
		chk1(alert_oe, 1'b1);
		rd(8'h02, v);
		chk8(v & 8'h10, 8'h10);
		rdc(8'h10, 8'h80);
		adc(10'h0bc, 10'h0b0, 1'b0);
		w(250);
		rd(8'h02, v);
		rd(8'h02, v);
		chk8(v & 8'h54, 8'h00);
		// Standby holds readings until a single shot
		wr(8'h09, 8'h40, 1'b0);
		w(250);
		rd(8'h02, v);
		chk1(v[7], 1'b0);
		adc(10'h050, 10'h0b0, 1'b0);
		w(250);
		rdc(8'h00, ti(10'h0bc));
		wr(8'h0f, 8'h00, 1'b1);
		rdc(8'h00, ti(10'h050));
		// Remote-only single shot leaves the local reading alone
		wr(8'h09, 8'h60, 1'b0);
		rdc(8'h03, 8'h60);
		adc(10'h064, 10'h0a4, 1'b0);
		wr(8'h0f, 8'h00, 1'b1);
		rdc(8'h00, ti(10'h050));
		rdc(8'h01, ti(10'h0a4));
		finish_test;
	end
endmodule // tb
